//--- sim/field_sensor_model.sv
// Field sensor and field supply model driving the conditioner inputs
`timescale 1ns/1ps
module field_sensor_model #(
  parameter int OFF_MV = 15000,
  parameter int ON_MV = 16000
) (
  // Clock and commanded field state
  input wire logic mclk_i,
  input wire logic [7:0] level_i,
  input wire logic [7:0] bounce_i,
  input wire logic hot_i,
  input wire logic [31:0] supply_mv_i,
  input wire logic reg_only_i,
  // Comparator and monitor results
  output logic [7:0] field_input_o,
  output logic over_temp_o,
  output logic below_off_o,
  output logic above_on_o,
  output logic reg_only_o
);
  logic phase_reg;
  initial phase_reg = 1'b0;
  initial field_input_o = 8'h00;
  // one means on, bouncing contacts flip each cycle
  always @(posedge mclk_i)
  begin
    phase_reg <= ~phase_reg;
    field_input_o <= level_i ^ (bounce_i & {8{phase_reg}});
  end
  assign over_temp_o = hot_i;
  // separate off and on trip levels
  assign below_off_o = supply_mv_i < 32'(OFF_MV);
  assign above_on_o = supply_mv_i > 32'(ON_MV);
  // supplied from the regulator pin only
  assign reg_only_o = reg_only_i;
endmodule // field_sensor_model

//--- sim/tb_top.sv
// Self-checking bench for the octal input conditioner
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("ERROR %s expected %h seen %h", nm, exp, got); \
    end \
  end
module tb_top;
  localparam logic [debounce_pkg::CNT_W-1:0] F2 = 17'h0_001e;
  localparam logic [debounce_pkg::CNT_W-1:0] F3 = 17'h0_003c;
  localparam logic [debounce_pkg::CNT_W-1:0] S2 = 17'h0_000a;
  localparam logic [debounce_pkg::CNT_W-1:0] S3 = 17'h0_0014;
  logic mclk_i, rst_i, ce_i, hot, reg_only, over_temp, below_off;
  logic above_on, reg_only_s, gen_n, uv_n, cur_red, tsel;
  logic [7:0] level, bounce, field, logic_output, exp_out, awaddr, araddr;
  logic [31:0] supply_mv, wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int n;
  int fc[3] = '{int'(debounce_pkg::FILT_CYC_1), int'(F2), int'(F3)};
  int sh[3] = '{int'(debounce_pkg::SW_HALF_1), int'(S2), int'(S3)};

  field_sensor_model u_field_sensor_model (
    .mclk_i(mclk_i), .level_i(level), .bounce_i(bounce), .hot_i(hot),
    .supply_mv_i(supply_mv), .reg_only_i(reg_only),
    .field_input_o(field), .over_temp_o(over_temp),
    .below_off_o(below_off), .above_on_o(above_on),
    .reg_only_o(reg_only_s));

  octal_input_top #(.FILT_CYC_2(F2), .FILT_CYC_3(F3), .SW_HALF_2(S2),
    .SW_HALF_3(S3)) u_octal_input_top (
    .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .field_input_i(field),
    .over_temp_i(over_temp), .supply_below_off_i(below_off),
    .supply_above_on_i(above_on), .regulator_only_i(reg_only_s),
    .logic_output_o(logic_output), .general_alarm_n_o(gen_n),
    .undervoltage_alarm_n_o(uv_n), .current_reduced_o(cur_red),
    .threshold_select_o(tsel), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready));

  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard well above the expected run length
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles >= 30000)
    begin
      num_errors++;
      $display("ERROR timeout expected 0 seen %0d", cycles);
      test_done();
    end
  end

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge mclk_i);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge mclk_i);
      if (!aw_ok && awready === 1'b1)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1)
      @(posedge mclk_i);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge mclk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
      @(posedge mclk_i);
    while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1)
      @(posedge mclk_i);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic set_code(input logic [1:0] code, input logic ts);
    axi_wr(debounce_pkg::REG_CTRL_ADDR, {29'h0000_0000, ts, code}, 4'hf,
           resp);
    `CHK("ctrl_wr_resp", debounce_pkg::RESP_OKAY, resp)
  endtask

  task automatic wcyc(input int k);
    repeat (k) @(posedge mclk_i);
  endtask

  // Cycles until the current phase output changes
  task automatic phase_len(output int k);
    logic lv;
    lv = cur_red;
    k = 0;
    do
    begin
      @(posedge mclk_i);
      k++;
    end
    while (cur_red === lv);
  endtask

  task automatic filt_step(input logic [1:0] code, input int cyc);
    set_code(code, 1'b1);
    level <= ~exp_out;
    wcyc(2 * cyc - 5);
    `CHK("held_level", exp_out, logic_output)
    exp_out = ~exp_out;
    wcyc(cyc + 15);
    `CHK("accepted_level", exp_out, logic_output)
  endtask

  task automatic alarm_step(input logic [31:0] mv, input logic g,
                            input logic u);
    supply_mv <= mv;
    wcyc(3);
    `CHK("general_alarm", g, gen_n)
    `CHK("uv_alarm", u, uv_n)
  endtask

  initial
  begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    level = 8'h00;
    bounce = 8'h00;
    hot = 1'b0;
    reg_only = 1'b0;
    supply_mv = 32'h0000_5dc0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wcyc(16);
    rst_i <= 1'b0;
    wcyc(3);
    `CHK("tsel_reset", 1'b1, tsel)
    `CHK("alarms_released", 2'h3, {gen_n, uv_n})
    axi_rd(debounce_pkg::REG_CTRL_ADDR, rd, resp);
    `CHK("ctrl_reset", 32'h0000_0004, rd)
    level <= 8'h3c;
    wcyc(4);
    `CHK("no_filter", 8'h3c, logic_output)
    exp_out = 8'h3c;
    n = 0;
    repeat (100)
    begin
      @(posedge mclk_i);
      if (cur_red !== 1'b0)
        n++;
    end
    `CHK("dc_current", 0, n)
    axi_rd(debounce_pkg::REG_STATUS_ADDR, rd, resp);
    `CHK("status", 32'h0000_033c, rd)
    axi_wr(debounce_pkg::REG_STATUS_ADDR, 32'hffff_ffff, 4'hf, resp);
    `CHK("ro_wr_resp", debounce_pkg::RESP_OKAY, resp)
    axi_wr(debounce_pkg::REG_CTRL_ADDR, 32'h0000_0003, 4'he, resp);
    axi_wr(8'h08, 32'h0000_0003, 4'hf, resp);
    `CHK("bad_wr_resp", debounce_pkg::RESP_SLVERR, resp)
    axi_rd(8'h08, rd, resp);
    `CHK("bad_rd_resp", debounce_pkg::RESP_SLVERR, resp)
    `CHK("bad_rd_data", 32'h0000_0000, rd)
    axi_rd(debounce_pkg::REG_CTRL_ADDR, rd, resp);
    `CHK("ctrl_kept", 32'h0000_0004, rd)
    set_code(2'h0, 1'b0);
    wcyc(2);
    `CHK("tsel_cmos", 1'b0, tsel)
    for (int i = 0; i < 3; i++)
      filt_step(2'(i + 1), fc[i]);
    level <= 8'h3c;
    bounce <= 8'h01;
    wcyc(4 * int'(F3));
    `CHK("bounce_dropped", 8'h3d, logic_output)
    bounce <= 8'h00;
    wcyc(4 * int'(F3));
    `CHK("bounce_settled", 8'h3c, logic_output)
    for (int i = 0; i < 3; i++)
    begin
      set_code(2'(i + 1), 1'b1);
      phase_len(n);
      phase_len(n);
      `CHK("phase_a", sh[i], n)
      phase_len(n);
      `CHK("phase_b", sh[i], n)
    end
    set_code(2'h0, 1'b1);
    hot <= 1'b1;
    wcyc(3);
    `CHK("hot_alarms", 2'h1, {gen_n, uv_n})
    hot <= 1'b0;
    alarm_step(32'h0000_3c8c, 1'b1, 1'b1);
    alarm_step(32'h0000_36b0, 1'b0, 1'b0);
    alarm_step(32'h0000_3c8c, 1'b0, 1'b0);
    alarm_step(32'h0000_4268, 1'b1, 1'b1);
    reg_only <= 1'b1;
    alarm_step(32'h0000_5dc0, 1'b0, 1'b0);
    `CHK("reg_only_gen", 1'b0, gen_n)
    reg_only <= 1'b0;
    alarm_step(32'h0000_5dc0, 1'b1, 1'b1);
    // Clock enable low freezes outputs and drops readys
    ce_i <= 1'b0;
    level <= 8'hc3;
    wcyc(4);
    `CHK("ce_frozen", 8'h3c, logic_output)
    `CHK("ce_ready", 1'b0, awready)
    ce_i <= 1'b1;
    wcyc(3);
    `CHK("ce_resumed", 8'hc3, logic_output)
    // Second reset in mid-run
    rst_i <= 1'b1;
    wcyc(2);
    `CHK("rst_out", 8'h00, logic_output)
    `CHK("rst_tsel", 1'b1, tsel)
    `CHK("rst_alarms", 2'h0, {gen_n, uv_n})
    rst_i <= 1'b0;
    wcyc(3);
    `CHK("rst_release", 8'hc3, logic_output)
    `CHK("rst_alarm_free", 2'h3, {gen_n, uv_n})
    test_done();
  end
endmodule // tb_top

//--- src/alarm_monitor.sv
// Temperature and field supply alarm outputs
`timescale 1ns/1ps
module alarm_monitor (
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Analog monitor results
  input wire logic over_temp_i,
  input wire logic supply_below_off_i,
  input wire logic supply_above_on_i,
  input wire logic regulator_only_i,
  // Active low alarms
  output logic general_alarm_n_o,
  output logic undervoltage_alarm_n_o
);
  typedef struct packed {
    logic uv;
    logic gen_n;
    logic uv_n;
  } alarm_state_s;

  alarm_state_s s_reg;
  alarm_state_s s_next;

  always_comb
  begin
    s_next = s_reg;
    // R12 enter undervoltage
    if (supply_below_off_i)
      s_next.uv = 1'b1;
    // R13 leave only above on level
    else if (supply_above_on_i)
      s_next.uv = 1'b0;
    // R14 regulator only forces alarms
    // R15 general alarm is OR, active low
    s_next.uv_n = !(s_next.uv || regulator_only_i);
    // R11 hot die raises general alarm
    s_next.gen_n = !(s_next.uv || regulator_only_i || over_temp_i);
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      s_reg <= '{uv: 1'b1, gen_n: 1'b0, uv_n: 1'b0};
    else if (ce_i)
      s_reg <= s_next;
  end

  assign general_alarm_n_o = s_reg.gen_n;
  assign undervoltage_alarm_n_o = s_reg.uv_n;

  chk_temp_alarm: assert property ( // R11
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && over_temp_i) |=> !general_alarm_n_o)
    else $error("Hot die without alarm");

  chk_uv_both_low: assert property ( // R12
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && supply_below_off_i)
    |=> !general_alarm_n_o && !undervoltage_alarm_n_o)
    else $error("Undervoltage not flagged on both");

  chk_uv_hysteresis: assert property ( // R13
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && s_reg.uv && !supply_above_on_i)
    |=> !undervoltage_alarm_n_o)
    else $error("Undervoltage released early");

  chk_regulator_only: assert property ( // R14
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && regulator_only_i) |=> !general_alarm_n_o[*1]
      ##0 !undervoltage_alarm_n_o)
    else $error("Alarms not forced in regulator mode");
endmodule // alarm_monitor

//--- src/channel_debounce.sv
// One channel of the glitch filter
`timescale 1ns/1ps
module channel_debounce (
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Filter timing
  input wire logic tick_i,
  input wire logic bypass_i,
  // Comparator result and filtered level
  input wire logic raw_i,
  output logic accepted_o
);
  typedef struct packed {
    logic acc;
    logic [1:0] cnt;
  } chan_state_s;

  chan_state_s s_reg;
  chan_state_s s_next;

  always_comb
  begin
    s_next = s_reg;
    if (bypass_i)
    begin
      s_next.acc = raw_i;
      s_next.cnt = '0;
    end
    // R4 drop short change
    else if (raw_i == s_reg.acc)
      s_next.cnt = '0;
    // R2 three stable ticks
    else if (tick_i)
    begin
      if (s_reg.cnt == debounce_pkg::TICK_CNT_LAST)
      begin
        s_next.acc = raw_i;
        s_next.cnt = '0;
      end
      else
        s_next.cnt = s_reg.cnt + 2'h1;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      s_reg <= '0;
    else if (ce_i)
      s_reg <= s_next;
  end

  assign accepted_o = s_reg.acc;

  chk_accept_three: assert property ( // R2
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && !bypass_i && tick_i && raw_i != s_reg.acc
      && s_reg.cnt == debounce_pkg::TICK_CNT_LAST)
    |=> accepted_o == $past(raw_i))
    else $error("Stable change not accepted");

  chk_glitch_dropped: assert property ( // R4
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && !bypass_i && raw_i == s_reg.acc)
    |=> s_reg.cnt == 2'h0 && accepted_o == $past(accepted_o))
    else $error("Short glitch not discarded");
endmodule // channel_debounce

//--- src/debounce_pkg.sv
// Constants shared by the octal input conditioner
package debounce_pkg;
  localparam int NUM_CH = 8;
  localparam int CLK_PERIOD_NS = 10;
  // Debounce times and current switching periods in ns
  localparam int DEB1_NS = 25_000;
  localparam int DEB2_NS = 750_000;
  localparam int DEB3_NS = 3_000_000;
  localparam int SW1_NS = 8_000;
  localparam int SW2_NS = 250_000;
  localparam int SW3_NS = 1_000_000;
  localparam int STABLE_TICKS = 3;
  localparam int TICK_DIV = STABLE_TICKS * CLK_PERIOD_NS;
  localparam int CNT_W = 17;
  // Filter clock periods in cycles, least time rounds up
  localparam logic [CNT_W-1:0] FILT_CYC_1 =
    CNT_W'((DEB1_NS + TICK_DIV - 1) / TICK_DIV);
  localparam logic [CNT_W-1:0] FILT_CYC_2 =
    CNT_W'((DEB2_NS + TICK_DIV - 1) / TICK_DIV);
  localparam logic [CNT_W-1:0] FILT_CYC_3 =
    CNT_W'((DEB3_NS + TICK_DIV - 1) / TICK_DIV);
  // Half switching periods in cycles for 50% duty
  localparam logic [CNT_W-1:0] SW_HALF_1 =
    CNT_W'(SW1_NS / (2 * CLK_PERIOD_NS));
  localparam logic [CNT_W-1:0] SW_HALF_2 =
    CNT_W'(SW2_NS / (2 * CLK_PERIOD_NS));
  localparam logic [CNT_W-1:0] SW_HALF_3 =
    CNT_W'(SW3_NS / (2 * CLK_PERIOD_NS));
  localparam logic [1:0] FSEL_OFF = 2'h0;
  localparam logic [1:0] FSEL_SHORT = 2'h1;
  localparam logic [1:0] FSEL_MID = 2'h2;
  localparam logic [1:0] FSEL_LONG = 2'h3;
  localparam logic [1:0] TICK_CNT_LAST = 2'(STABLE_TICKS - 1);
  // Register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS_ADDR = 8'h04;
  localparam int CTRL_FSEL_LSB = 0;
  localparam int CTRL_TSEL_BIT = 2;
  localparam int STAT_OUT_LSB = 0;
  localparam int STAT_ALARM_BIT = 8;
  localparam int STAT_UV_BIT = 9;
  localparam int STAT_CUR_BIT = 10;
  localparam logic [1:0] CTRL_FSEL_RST = 2'h0;
  localparam logic CTRL_TSEL_RST = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- src/octal_input_top.sv
// Octal input conditioner with AXI4-Lite control
// Behaviour
// R1 - Filter select code 0 none, 1 25us, 2 0.75ms, 3 3ms
// R2 - A change is accepted only after three stable filter clock ticks
// R3 - Filter clock period is one third of the debounce time
// R4 - A change that does not persist is dropped, old state kept
// R5 - Each channel's filtered level drives its own logic output
// R6 - Comparator result 1 means sensor on, 0 off
// R7 - Threshold select 1 industrial trip points, 0 CMOS near 2.5V
// R8 - Filter clock toggles input current between full and one fifth
// R9 - Current switching spends equal time at each level
// R10 - Switch period per code: off, 8us, 0.25ms, 1ms
// R11 - Over-temperature raises the general alarm
// R12 - Supply below off level raises both alarms
// R13 - Both alarms release only above the on level
// R14 - Regulator-only supply holds both alarms active
// R15 - Alarms active low; general alarm ORs temperature and supply
// R16 - Eight independent channel filters share one filter clock
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module octal_input_top #(
  parameter logic [debounce_pkg::CNT_W-1:0] FILT_CYC_2 =
    debounce_pkg::FILT_CYC_2,
  parameter logic [debounce_pkg::CNT_W-1:0] FILT_CYC_3 =
    debounce_pkg::FILT_CYC_3,
  parameter logic [debounce_pkg::CNT_W-1:0] SW_HALF_2 =
    debounce_pkg::SW_HALF_2,
  parameter logic [debounce_pkg::CNT_W-1:0] SW_HALF_3 =
    debounce_pkg::SW_HALF_3
) (
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Comparator results and monitors
  input wire logic [debounce_pkg::NUM_CH-1:0] field_input_i,
  input wire logic over_temp_i,
  input wire logic supply_below_off_i,
  input wire logic supply_above_on_i,
  input wire logic regulator_only_i,
  // Outputs to controller and analog front end
  output logic [debounce_pkg::NUM_CH-1:0] logic_output_o,
  output logic general_alarm_n_o,
  output logic undervoltage_alarm_n_o,
  output logic current_reduced_o,
  output logic threshold_select_o,
  // AXI4-Lite write channels
  input wire logic [debounce_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read channels
  input wire logic [debounce_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);
  localparam int CW = debounce_pkg::CNT_W;

  typedef struct packed {
    logic [1:0] fsel;
    logic tsel;
    logic [CW-1:0] filt_cnt;
    logic [CW-1:0] sw_cnt;
    logic cur_red;
    logic aw_full;
    logic [debounce_pkg::ADDR_W-1:0] awaddr;
    logic w_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } top_state_s;

  localparam top_state_s RESET_STATE = '{
    fsel: debounce_pkg::CTRL_FSEL_RST,
    tsel: debounce_pkg::CTRL_TSEL_RST,
    default: '0
  };

  top_state_s s_reg;
  top_state_s s_next;

  // Count for a select code, zero when filtering is off
  function automatic logic [CW-1:0] pick_count(
    input logic [1:0] code,
    input logic [CW-1:0] c1,
    input logic [CW-1:0] c2,
    input logic [CW-1:0] c3
  );
    case (code)
      debounce_pkg::FSEL_SHORT: pick_count = c1;
      debounce_pkg::FSEL_MID: pick_count = c2;
      debounce_pkg::FSEL_LONG: pick_count = c3;
      default: pick_count = '0;
    endcase
  endfunction

  function automatic logic is_mapped(
    input logic [debounce_pkg::ADDR_W-1:0] addr
  );
    is_mapped = (addr == debounce_pkg::REG_CTRL_ADDR) ||
      (addr == debounce_pkg::REG_STATUS_ADDR);
  endfunction

  logic [CW-1:0] filt_lim;
  logic [CW-1:0] sw_lim;
  logic filt_off;
  logic filt_tick;
  logic sw_tick;
  logic do_write;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic [31:0] status_word;
  logic [31:0] ctrl_word;

  // R1 debounce time per code
  // R3 tick every third of debounce time
  assign filt_lim = pick_count(s_reg.fsel, debounce_pkg::FILT_CYC_1,
    FILT_CYC_2, FILT_CYC_3);
  // R10 half switching period per code
  assign sw_lim = pick_count(s_reg.fsel, debounce_pkg::SW_HALF_1,
    SW_HALF_2, SW_HALF_3);
  assign filt_off = (s_reg.fsel == debounce_pkg::FSEL_OFF);
  assign filt_tick = !filt_off && (s_reg.filt_cnt >= filt_lim - CW'(1));
  assign sw_tick = !filt_off && (s_reg.sw_cnt >= sw_lim - CW'(1));

  assign s_axi_awready_o = ce_i && !s_reg.aw_full;
  assign s_axi_wready_o = ce_i && !s_reg.w_full;
  assign s_axi_arready_o = ce_i && !s_reg.rvalid;
  assign aw_hs = s_axi_awvalid_i && s_axi_awready_o;
  assign w_hs = s_axi_wvalid_i && s_axi_wready_o;
  assign ar_hs = s_axi_arvalid_i && s_axi_arready_o;
  assign do_write = s_reg.aw_full && s_reg.w_full && !s_reg.bvalid;

  always_comb
  begin
    ctrl_word = '0;
    ctrl_word[debounce_pkg::CTRL_FSEL_LSB +: 2] = s_reg.fsel;
    ctrl_word[debounce_pkg::CTRL_TSEL_BIT] = s_reg.tsel;
    status_word = '0;
    status_word[debounce_pkg::STAT_OUT_LSB +: debounce_pkg::NUM_CH] =
      logic_output_o;
    status_word[debounce_pkg::STAT_ALARM_BIT] = general_alarm_n_o;
    status_word[debounce_pkg::STAT_UV_BIT] = undervoltage_alarm_n_o;
    status_word[debounce_pkg::STAT_CUR_BIT] = s_reg.cur_red;
  end

  always_comb
  begin
    s_next = s_reg;
    // Filter clock divider
    if (filt_off || filt_tick)
      s_next.filt_cnt = '0;
    else
      s_next.filt_cnt = s_reg.filt_cnt + CW'(1);
    // R8 reduced current phase
    // R9 equal half periods
    if (filt_off)
    begin
      s_next.sw_cnt = '0;
      s_next.cur_red = 1'b0;
    end
    else if (sw_tick)
    begin
      s_next.sw_cnt = '0;
      s_next.cur_red = !s_reg.cur_red;
    end
    else
      s_next.sw_cnt = s_reg.sw_cnt + CW'(1);
    // Write address and data held until both present
    if (aw_hs)
    begin
      s_next.aw_full = 1'b1;
      s_next.awaddr = s_axi_awaddr_i;
    end
    if (w_hs)
    begin
      s_next.w_full = 1'b1;
      s_next.wdata = s_axi_wdata_i;
      s_next.wstrb = s_axi_wstrb_i;
    end
    if (do_write)
    begin
      s_next.aw_full = 1'b0;
      s_next.w_full = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = is_mapped(s_reg.awaddr) ?
        debounce_pkg::RESP_OKAY : debounce_pkg::RESP_SLVERR;
      // R7 threshold select from software
      if (s_reg.awaddr == debounce_pkg::REG_CTRL_ADDR && s_reg.wstrb[0])
      begin
        // R3 restart dividers on a new code
        if (s_reg.wdata[debounce_pkg::CTRL_FSEL_LSB +: 2] != s_reg.fsel)
        begin
          s_next.filt_cnt = '0;
          s_next.sw_cnt = '0;
        end
        s_next.fsel = s_reg.wdata[debounce_pkg::CTRL_FSEL_LSB +: 2];
        s_next.tsel = s_reg.wdata[debounce_pkg::CTRL_TSEL_BIT];
      end
    end
    else if (s_reg.bvalid && s_axi_bready_i)
      s_next.bvalid = 1'b0;
    // Read
    if (ar_hs)
    begin
      s_next.rvalid = 1'b1;
      s_next.rresp = is_mapped(s_axi_araddr_i) ?
        debounce_pkg::RESP_OKAY : debounce_pkg::RESP_SLVERR;
      case (s_axi_araddr_i)
        debounce_pkg::REG_CTRL_ADDR: s_next.rdata = ctrl_word;
        debounce_pkg::REG_STATUS_ADDR: s_next.rdata = status_word;
        default: s_next.rdata = '0;
      endcase
    end
    else if (s_reg.rvalid && s_axi_rready_i)
      s_next.rvalid = 1'b0;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      s_reg <= RESET_STATE;
    else if (ce_i)
      s_reg <= s_next;
  end

  assign s_axi_bvalid_o = s_reg.bvalid;
  assign s_axi_bresp_o = s_reg.bresp;
  assign s_axi_rvalid_o = s_reg.rvalid;
  assign s_axi_rdata_o = s_reg.rdata;
  assign s_axi_rresp_o = s_reg.rresp;
  assign current_reduced_o = s_reg.cur_red;
  // R7 trip points chosen in the analog comparators
  assign threshold_select_o = s_reg.tsel;

  // R16 one filter per channel, shared tick
  // R5 parallel outputs
  for (genvar g = 0; g < debounce_pkg::NUM_CH; g++)
  begin : g_ch
    channel_debounce u_ch (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .tick_i(filt_tick),
      .bypass_i(filt_off),
      .raw_i(field_input_i[g]),
      .accepted_o(logic_output_o[g])
    );
  end

  alarm_monitor u_alarm (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .over_temp_i(over_temp_i),
    .supply_below_off_i(supply_below_off_i),
    .supply_above_on_i(supply_above_on_i),
    .regulator_only_i(regulator_only_i),
    .general_alarm_n_o(general_alarm_n_o),
    .undervoltage_alarm_n_o(undervoltage_alarm_n_o)
  );

  chk_no_filter_pass: assert property ( // R1
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && filt_off) |=> logic_output_o == $past(field_input_i))
    else $error("Code zero did not pass input through");

  chk_short_tick: assert property ( // R3
    @(posedge mclk_i) disable iff (rst_i)
    (filt_tick && s_reg.fsel == debounce_pkg::FSEL_SHORT)
    |-> s_reg.filt_cnt == debounce_pkg::FILT_CYC_1 - CW'(1))
    else $error("Short filter tick at wrong count");

  chk_long_tick: assert property ( // R3
    @(posedge mclk_i) disable iff (rst_i)
    (filt_tick && s_reg.fsel == debounce_pkg::FSEL_LONG)
    |-> s_reg.filt_cnt == FILT_CYC_3 - CW'(1))
    else $error("Long filter tick at wrong count");

  chk_current_toggle: assert property ( // R8
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && sw_tick) |=> current_reduced_o != $past(current_reduced_o))
    else $error("Current phase did not toggle");

  chk_half_period: assert property ( // R9
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && !sw_tick && !filt_off)
    |=> current_reduced_o == $past(current_reduced_o))
    else $error("Current phase changed mid half period");

  chk_off_full_current: assert property ( // R10
    @(posedge mclk_i) disable iff (rst_i)
    (filt_off && $past(filt_off) && $past(ce_i)) |-> !current_reduced_o)
    else $error("Switching active with code zero");

  chk_tsel_write: assert property ( // R7
    @(posedge mclk_i) disable iff (rst_i)
    (ce_i && do_write && s_reg.wstrb[0]
      && s_reg.awaddr == debounce_pkg::REG_CTRL_ADDR)
    |=> threshold_select_o ==
      $past(s_reg.wdata[debounce_pkg::CTRL_TSEL_BIT]))
    else $error("Threshold select not written");

  chk_alarm_or: assert property ( // R15
    @(posedge mclk_i) disable iff (rst_i)
    !undervoltage_alarm_n_o |-> !general_alarm_n_o)
    else $error("Supply alarm missing from general alarm");
endmodule // octal_input_top
